// >>> include/ctp_pkg.sv
// Constants for the compact timer: register map, fields, codes.
// Assumes an 8-bit register port with a 3-bit address.
package ctp_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CNT_W = 10;
    // Register offsets
    localparam logic [2:0] OFS_CTL_A = 3'h0;
    localparam logic [2:0] OFS_CTL_B = 3'h1;
    localparam logic [2:0] OFS_CNT_LO = 3'h2;
    localparam logic [2:0] OFS_CNT_HI = 3'h3;
    localparam logic [2:0] OFS_CMP_LO = 3'h4;
    localparam logic [2:0] OFS_CMP_HI = 3'h5;
    // Reset values
    localparam logic [7:0] CTL_A_RST = 8'h00;
    localparam logic [7:0] CTL_B_RST = 8'h00;
    localparam logic [9:0] CNT_RST = 10'h000;
    localparam logic [9:0] CMP_RST = 10'h000;
    // timer_control_a fields
    localparam int PAUSE_POS = 7;
    localparam int CKSEL_LSB = 4;
    localparam int ON_POS = 3;
    localparam int RP_LSB = 0;
    // timer_control_b fields
    localparam int MODE_LSB = 6;
    localparam int IO_LSB = 4;
    localparam int OC_POS = 3;
    localparam int POL_POS = 2;
    localparam int DPX_POS = 1;
    localparam int CCLR_POS = 0;
    // Counter bits seen by the period comparator
    localparam int PER_LSB = 7;
    // Clock select codes
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H16 = 3'h2;
    localparam logic [2:0] CK_H64 = 3'h3;
    localparam logic [2:0] CK_SUB = 3'h4;
    localparam logic [2:0] CK_PINR = 3'h6;
    localparam logic [2:0] CK_PINF = 3'h7;
    // Operating modes
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    // Output function codes
    localparam logic [1:0] IO_HOLD = 2'h0;
    localparam logic [1:0] IO_LOW = 2'h1;
    localparam logic [1:0] IO_HIGH = 2'h2;
    localparam logic [1:0] IO_TOGG = 2'h3;
endpackage

// >>> hdl/ctp_timer.sv
// Compact 10-bit timer with compare output and PWM, byte registers.
// Assumes synchronous inputs and one-cycle tick inputs for the high
// speed and sub clocks, both taken on SYS_CLK_I.
//
// Function
// - Pause bit holds the counter value.
// - Clearing pause resumes from held value.
// - Clock select field picks counter clock source.
// - On-bit rising clears counter, starts counting.
// - On-bit falling stops, keeps counter value.
// - On-bit rising restores initial compare output level.
// - Period value matches counter bits 9 to 7.
// - Period value zero lets counter overflow.
// - Mode field selects compare, PWM, timer.
// - Full match drives pin per output field.
// - PWM output field forces or drives waveform.
// - Output control sets initial level or polarity.
// - Invert bit inverts the timer output pin.
// - Timer mode disables the output pin.
// - Swap bit exchanges period and duty roles.
// - Clear select picks full or period clear.
// - Clear select ignored in PWM mode.
// - Counter and compare readable as byte pairs.
// - Compare low write goes to holding buffer.
// - High byte read latches low byte buffer.
// - Full comparator checks all ten counter bits.
`timescale 1ns/1ns
module ctp_timer (
    input wire logic SYS_CLK_I,
    input wire logic SRST_I,
    input wire logic [ctp_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [ctp_pkg::DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [ctp_pkg::DATA_W-1:0] RDATA_O,
    input wire logic HCLK_TICK_I,
    input wire logic SUBCLK_TICK_I,
    input wire logic EXT_CLK_I,
    output logic TMR_OUT_O,
    output logic TMR_OUT_OE_N_O
);
    import ctp_pkg::*;

    logic [7:0] ctla_reg;
    logic [7:0] ctla_next;
    logic [7:0] ctlb_reg;
    logic [7:0] ctlb_next;
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic [9:0] cmp_reg;
    logic [9:0] cmp_next;
    logic [7:0] hold_reg;
    logic [7:0] hold_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [1:0] div4_reg;
    logic [5:0] hdiv_reg;
    logic [5:0] hdiv_next;
    logic ext_reg;
    logic out_reg;
    logic out_next;
    logic pin_reg;
    logic pin_next;
    logic oe_n_reg;

    // Register decode
    wire wr_ca = WR_I & (ADDR_I == OFS_CTL_A);
    wire wr_cb = WR_I & (ADDR_I == OFS_CTL_B);
    wire wr_al = WR_I & (ADDR_I == OFS_CMP_LO);
    wire wr_ah = WR_I & (ADDR_I == OFS_CMP_HI);
    wire rd_dh = RD_I & (ADDR_I == OFS_CNT_HI);
    wire rd_ah = RD_I & (ADDR_I == OFS_CMP_HI);

    // Control fields
    wire pause = ctla_reg[PAUSE_POS];
    wire [2:0] cksel = ctla_reg[CKSEL_LSB +: 3];
    wire run_on = ctla_reg[ON_POS];
    wire [2:0] rp = ctla_reg[RP_LSB +: 3];
    wire [1:0] mode = ctlb_reg[MODE_LSB +: 2];
    wire [1:0] iof = ctlb_reg[IO_LSB +: 2];
    wire oc = ctlb_reg[OC_POS];
    wire pol = ctlb_reg[POL_POS];
    wire dpx = ctlb_reg[DPX_POS];
    wire cclr = ctlb_reg[CCLR_POS];
    wire is_pwm = (mode == MODE_PWM);
    wire is_cmp = (mode == MODE_CMP);

    // Only a written 0 to 1 edge restarts; a rewrite of 1 does not
    wire on_rise = wr_ca & WDATA_I[ON_POS] & ~run_on;

    // Clock source ticks, all as enables of the one system clock
    wire tick_s4 = (div4_reg == 2'h3);
    wire tick_h16 = HCLK_TICK_I & (hdiv_reg[3:0] == 4'hF);
    wire tick_h64 = HCLK_TICK_I & (hdiv_reg == 6'h3F);
    wire ext_rise = EXT_CLK_I & ~ext_reg;
    wire ext_fall = ~EXT_CLK_I & ext_reg;
    assign hdiv_next = HCLK_TICK_I ? hdiv_reg + 6'h01 : hdiv_reg;

    function automatic logic pick_tick(
        input logic [2:0] sel,
        input logic s4,
        input logic h16,
        input logic h64,
        input logic sub,
        input logic er,
        input logic ef
    );
        logic t;
        t = 1'b0;
        unique case (sel)
            CK_SYS4: t = s4;
            CK_SYS: t = 1'b1;
            CK_H16: t = h16;
            CK_H64: t = h64;
            CK_SUB: t = sub;
            CK_PINR: t = er;
            CK_PINF: t = ef;
            default: t = 1'b0; // Code 101 never counts
        endcase
        return t;
    endfunction

    wire tick = pick_tick(cksel, tick_s4, tick_h16, tick_h64,
        SUBCLK_TICK_I, ext_rise, ext_fall);

    // Advance only while on and not paused
    wire adv = run_on & ~pause & tick;
    wire [9:0] cnt_inc = cnt_reg + 10'h001;

    // Matches are judged on the value about to be reached, so code n
    // gives a period of exactly n*128 clocks
    wire p_hit = adv & (rp != 3'h0) & (cnt_inc[PER_LSB +: 3] == rp);
    // A zero compare value would only alias the wrap
    wire a_hit = adv & (cmp_reg != 10'h000) & (cnt_inc == cmp_reg);

    // PWM clears on the period comparator, or on the full one when the swap bit is set
    wire clr_on_a = is_pwm ? dpx : cclr;
    wire clr_hit = clr_on_a ? a_hit : p_hit;

    // Wrap to zero on overflow is natural
    assign cnt_next = on_rise ? CNT_RST :
        adv ? (clr_hit ? CNT_RST : cnt_inc) : cnt_reg;

    // PWM duty: the count stays below the duty value
    wire duty_a = (cnt_reg < cmp_reg);
    wire duty_p = (rp == 3'h0) | (cnt_reg < {rp, 7'h00});
    wire pwm_act = dpx ? duty_p : duty_a;

    // Active level follows output control
    wire pwm_lvl = (iof == IO_LOW) ? oc :
        (iof == IO_HIGH) ? (pwm_act ? oc : ~oc) : ~oc;

    // Compare output action on a full match
    wire cmp_lvl = (iof == IO_LOW) ? 1'b0 :
        (iof == IO_HIGH) ? 1'b1 :
        (iof == IO_TOGG) ? ~out_reg : out_reg;

    assign out_next = (on_rise & is_cmp) ? oc :
        (is_cmp & a_hit) ? cmp_lvl : out_reg;

    // Pin is parked low and released outside the two pin modes
    assign pin_next = (is_pwm | is_cmp) &
        ((is_pwm ? pwm_lvl : out_reg) ^ pol);

    // Register writes
    assign ctla_next = wr_ca ? WDATA_I : ctla_reg;
    assign ctlb_next = wr_cb ? WDATA_I : ctlb_reg;

    // One buffer is shared by both pairs, so interleaved pair
    // accesses corrupt each other
    assign hold_next = wr_al ? WDATA_I :
        rd_dh ? cnt_reg[7:0] :
        rd_ah ? cmp_reg[7:0] : hold_reg;
    assign cmp_next = wr_ah ? {WDATA_I[1:0], hold_reg} : cmp_reg;

    // Read data stand only in the cycle after the strobe
    wire [7:0] rd_mux =
        (ADDR_I == OFS_CTL_A) ? ctla_reg :
        (ADDR_I == OFS_CTL_B) ? ctlb_reg :
        (ADDR_I == OFS_CNT_LO) ? hold_reg :
        (ADDR_I == OFS_CNT_HI) ? {6'h00, cnt_reg[9:8]} :
        (ADDR_I == OFS_CMP_LO) ? hold_reg :
        (ADDR_I == OFS_CMP_HI) ? {6'h00, cmp_reg[9:8]} : 8'h00;
    assign rdata_next = RD_I ? rd_mux : 8'h00;

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            ctla_reg <= CTL_A_RST;
            ctlb_reg <= CTL_B_RST;
            cmp_reg <= CMP_RST;
            hold_reg <= 8'h00;
            rdata_reg <= 8'h00;
        end else begin
            ctla_reg <= ctla_next;
            ctlb_reg <= ctlb_next;
            cmp_reg <= cmp_next;
            hold_reg <= hold_next;
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            cnt_reg <= CNT_RST;
            div4_reg <= 2'h0;
            hdiv_reg <= 6'h00;
            ext_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            div4_reg <= div4_reg + 2'h1;
            hdiv_reg <= hdiv_next;
            ext_reg <= EXT_CLK_I;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            out_reg <= 1'b0;
            pin_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            out_reg <= out_next;
            pin_reg <= pin_next;
            oe_n_reg <= ~(is_pwm | is_cmp);
        end
    end

    assign RDATA_O = rdata_reg;
    assign TMR_OUT_O = pin_reg;
    assign TMR_OUT_OE_N_O = oe_n_reg;

    // Checks
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (SRST_I);

    a_pause_holds: assert property (
        (pause & ~wr_ca) |=> (cnt_reg == $past(cnt_reg)))
        else $error("counter moved while paused");

    a_count_step: assert property (
        (adv & ~clr_hit & ~wr_ca & cnt_reg != 10'h3FF)
        |=> (cnt_reg == $past(cnt_reg) + 10'h001))
        else $error("counter did not step by one");

    a_resume_value: assert property (
        ((pause & ~on_rise) ##1 (~pause & ~wr_ca & ~adv))
        |=> (cnt_reg == $past(cnt_reg, 2)))
        else $error("counter lost value over pause");

    a_on_clears: assert property (
        on_rise |=> (cnt_reg == 10'h000))
        else $error("on edge did not clear counter");

    a_off_holds: assert property (
        (~run_on & ~on_rise) |=> $stable(cnt_reg))
        else $error("counter moved while off");

    a_init_level: assert property (
        (on_rise & is_cmp) |=> (out_reg == $past(oc)))
        else $error("output not set to initial level");

    a_period_clear: assert property (
        (p_hit & ~clr_on_a & ~on_rise) |=> (cnt_reg == 10'h000))
        else $error("period match did not clear");

    a_full_clear: assert property (
        (a_hit & clr_on_a & ~on_rise) |=> (cnt_reg == 10'h000))
        else $error("full match did not clear");

    a_match_high: assert property (
        (is_cmp & a_hit & ~on_rise & iof == IO_HIGH)
        |=> out_reg ##1 (TMR_OUT_O == ~$past(pol)))
        else $error("output not driven high on match");

    a_pwm_force: assert property (
        (is_pwm & iof == IO_HOLD) |=> (TMR_OUT_O == ($past(oc)
        ^ ~$past(pol))))
        else $error("pwm inactive level wrong");

    a_timer_off: assert property (
        (mode == MODE_TMR) |=> (TMR_OUT_OE_N_O & ~TMR_OUT_O))
        else $error("pin enabled in timer mode");

    a_buffer_load: assert property (
        wr_ah |=> (cmp_reg == {$past(WDATA_I[1:0]),
        $past(hold_reg)}))
        else $error("compare pair write wrong");

    a_read_latch: assert property (
        rd_dh |=> (hold_reg == $past(cnt_reg[7:0])))
        else $error("high read did not latch low byte");

    a_clock_select: assert property (
        (run_on & ~pause & cksel == CK_SYS & ~clr_hit)
        |=> (cnt_reg == $past(cnt_inc)))
        else $error("system clock did not count");

    a_no_source: assert property (
        (cksel == 3'h5 & ~on_rise) |=> $stable(cnt_reg))
        else $error("undefined clock code counted");

    a_overflow_wrap: assert property (
        (adv & cnt_reg == 10'h3FF) |=> (cnt_reg == 10'h000))
        else $error("counter did not wrap");

    a_pin_enabled: assert property (
        (is_cmp | is_pwm) |=> ~TMR_OUT_OE_N_O)
        else $error("pin not driven in pin mode");

    a_match_low: assert property (
        (is_cmp & a_hit & iof == IO_LOW) |=> ~out_reg)
        else $error("output not driven low on match");

    a_match_toggle: assert property (
        (is_cmp & a_hit & iof == IO_TOGG)
        |=> (out_reg != $past(out_reg)))
        else $error("output did not toggle on match");

    a_no_hit_hold: assert property (
        (is_cmp & ~a_hit & ~on_rise) |=> $stable(out_reg))
        else $error("output moved without a match");

    a_invert_pin: assert property (
        (is_cmp & pol) |=> (TMR_OUT_O == ~$past(out_reg)))
        else $error("pin not inverted");

    a_pwm_active: assert property (
        (is_pwm & iof == IO_LOW)
        |=> (TMR_OUT_O == ($past(oc) ^ $past(pol))))
        else $error("pwm active level wrong");

    a_pwm_duty: assert property (
        (is_pwm & iof == IO_HIGH & ~dpx & cnt_reg < cmp_reg)
        |=> (TMR_OUT_O == ($past(oc) ^ $past(pol))))
        else $error("pwm not active inside duty");

    a_pwm_idle: assert property (
        (is_pwm & iof == IO_HIGH & ~dpx & cnt_reg >= cmp_reg)
        |=> (TMR_OUT_O == ~($past(oc) ^ $past(pol))))
        else $error("pwm active outside duty");

    a_swap_period: assert property (
        (is_pwm & dpx & a_hit) |=> (cnt_reg == 10'h000))
        else $error("swapped period did not clear");

    a_clear_ignored: assert property (
        (is_pwm & ~dpx & cclr & a_hit & ~p_hit)
        |=> (cnt_reg != 10'h000))
        else $error("clear select used in pwm mode");

    a_read_data: assert property (
        (RD_I & ADDR_I == OFS_CNT_HI)
        |=> (RDATA_O == {6'h00, $past(cnt_reg[9:8])}))
        else $error("counter high read wrong");

    a_read_idle: assert property (
        ~RD_I |=> (RDATA_O == 8'h00))
        else $error("read data outside read cycle");

    a_match_pulse: assert property (
        (a_hit & cmp_reg != 10'h001 & ~wr_ah) |=> ~a_hit)
        else $error("full match longer than a cycle");

    a_upper_bits: assert property (
        (adv & cnt_inc[6:0] == cmp_reg[6:0]
        & cnt_inc[9:7] != cmp_reg[9:7]) |-> ~a_hit)
        else $error("full match ignored upper bits");

    c_pwm_run: cover property (is_pwm & iof == IO_HIGH & clr_hit);
    c_cmp_toggle: cover property (is_cmp & a_hit & iof == IO_TOGG);
    c_overflow: cover property (adv & cnt_reg == 10'h3FF);
    c_pause_resume: cover property (pause ##1 ~pause ##1 adv);
    c_swap_pwm: cover property (is_pwm & dpx & a_hit);
endmodule

// >>> verification/ctp_timer_tb.sv
// Self-checking bench for the compact timer: bus, counter, output pin.
// Assumes the package and the timer module are compiled first.
`timescale 1ns/1ns
module ctp_timer_tb;
    import ctp_pkg::*;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic hck = 1'h0;
    logic sck = 1'h0;
    logic ext = 1'h0;
    logic [1:0] ph = 2'h0;
    logic [2:0] adr = 3'h0;
    logic [7:0] wd = 8'h00;
    wire logic [7:0] rdat;
    wire logic pin;
    wire logic oen;
    int failures = 0;
    int n_compared = 0;
    int hi_n;
    int tg_n;
    always #10 clk = ~clk;
    // Tick sources: sub every 2nd cycle, high 3 of 4, pin period 4
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        sck <= ph[0];
        hck <= ~&ph;
        ext <= ph[1];
    end
    ctp_timer dut (.SYS_CLK_I(clk), .SRST_I(srst), .ADDR_I(adr),
        .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat),
        .HCLK_TICK_I(hck), .SUBCLK_TICK_I(sck), .EXT_CLK_I(ext),
        .TMR_OUT_O(pin), .TMR_OUT_OE_N_O(oen));
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'h1) begin
            failures++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'h1;
        adr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rreg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'h1;
        adr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdat;
    endtask
    // High byte first, so the low byte comes from the shared buffer
    task automatic rcnt(output logic [9:0] c);
        logic [7:0] h;
        logic [7:0] l;
        rreg(OFS_CNT_HI, h);
        rreg(OFS_CNT_LO, l);
        c = {h[1:0], l};
    endtask
    task automatic run(input int n);
        logic last;
        hi_n = 0;
        tg_n = 0;
        last = pin;
        repeat (n) begin
            @(posedge clk);
            #1;
            hi_n += int'(pin === 1'h1);
            tg_n += int'(pin !== last);
            last = pin;
        end
    endtask
    task automatic t_regs;
        logic [7:0] d;
        for (int a = 0; a < 8; a++) begin
            rreg(3'(a), d);
            chk(d === 8'h00, "reset value");
        end
        wreg(OFS_CNT_LO, 8'hFF);
        wreg(OFS_CNT_HI, 8'hFF);
        wreg(3'h6, 8'hFF);
        wreg(OFS_CMP_LO, 8'hA5);
        wreg(OFS_CMP_HI, 8'hFF);
        rreg(OFS_CMP_HI, d);
        chk(d === 8'h03, "compare high");
        wreg(OFS_CMP_LO, 8'h11);
        rreg(OFS_CMP_HI, d);
        rreg(OFS_CMP_LO, d);
        chk(d === 8'hA5, "compare low buffered");
        rreg(3'h6, d);
        chk(d === 8'h00, "unmapped read");
        rreg(OFS_CNT_HI, d);
        rreg(OFS_CNT_LO, d);
        chk(d === 8'h00, "counter is read only");
    endtask
    task automatic t_clocks;
        int e [8] = '{128, 512, 24, 6, 256, 0, 128, 128};
        logic [9:0] c;
        int d;
        wreg(OFS_CTL_B, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wreg(OFS_CTL_A, {1'h0, 3'(k), 4'h0});
            wreg(OFS_CTL_A, {1'h0, 3'(k), 4'h8});
            run(510);
            wreg(OFS_CTL_A, {1'h0, 3'(k), 4'h0});
            rcnt(c);
            // Signed difference, so an expected count of zero still works
            d = int'(c) - e[k];
            chk(d >= -2 && d <= 2, "source count");
        end
    endtask
    task automatic t_pause;
        logic [9:0] c1;
        logic [9:0] c2;
        wreg(OFS_CTL_A, 8'h18);
        run(100);
        wreg(OFS_CTL_A, 8'h98);
        rcnt(c1);
        run(20);
        rcnt(c2);
        chk(c1 === c2 && c1 > 10'd90, "paused count");
        wreg(OFS_CTL_A, 8'h18);
        run(50);
        wreg(OFS_CTL_A, 8'h10);
        rcnt(c2);
        chk(c2 >= c1 + 50 && c2 <= c1 + 56, "resumed count");
        run(20);
        rcnt(c1);
        chk(c1 === c2, "off keeps count");
        wreg(OFS_CTL_A, 8'h18);
        wreg(OFS_CTL_A, 8'h10);
        rcnt(c1);
        chk(c1 <= 10'd3, "on clears count");
    endtask
    task automatic t_cmp;
        wreg(OFS_CMP_LO, 8'hE8);
        wreg(OFS_CMP_HI, 8'h03);
        wreg(OFS_CTL_B, 8'h18);
        wreg(OFS_CTL_A, 8'h18);
        run(10);
        chk(pin === 1'h1 && oen === 1'h0, "initial high");
        run(980);
        chk(pin === 1'h1, "no early match");
        run(30);
        chk(pin === 1'h0, "match drives low");
        wreg(OFS_CTL_B, 8'h1C);
        run(3);
        chk(pin === 1'h1, "inverted pin");
        wreg(OFS_CTL_A, 8'h10);
        wreg(OFS_CTL_A, 8'h18);
        run(3);
        chk(pin === 1'h0, "initial level back");
        // Full clear at 5 toggles the pin every 5 cycles
        wreg(OFS_CTL_A, 8'h10);
        wreg(OFS_CMP_LO, 8'h05);
        wreg(OFS_CMP_HI, 8'h00);
        wreg(OFS_CTL_B, 8'h31);
        wreg(OFS_CTL_A, 8'h18);
        run(100);
        chk(tg_n >= 19 && tg_n <= 21, "full clear period");
        wreg(OFS_CMP_LO, 8'h40);
        wreg(OFS_CTL_B, 8'h30);
        wreg(OFS_CTL_A, 8'h19);
        run(1100);
        run(1280);
        chk(tg_n >= 9 && tg_n <= 11, "period 128");
        wreg(OFS_CTL_A, 8'h18);
        run(1100);
        run(2048);
        chk(tg_n >= 1 && tg_n <= 3, "overflow 1024");
        // Initial low, then the match drives the pin high
        wreg(OFS_CTL_A, 8'h10);
        wreg(OFS_CTL_B, 8'h20);
        wreg(OFS_CTL_A, 8'h18);
        run(3);
        chk(pin === 1'h0, "initial low");
        run(5);
        chk(pin === 1'h1, "match drives high");
        wreg(OFS_CTL_A, 8'h10);
        wreg(OFS_CTL_B, 8'hC0);
        run(3);
        chk(oen === 1'h1 && pin === 1'h0, "pin released");
    endtask
    task automatic t_pwm;
        logic [7:0] cb [7] = '{8'hA8, 8'hA9, 8'hAC, 8'hA0, 8'h88, 8'h98,
            8'hAA};
        int e [7] = '{320, 320, 960, 960, 0, 1280, 1280};
        int d;
        // Period 128, duty 32; last entry swaps to period 64, duty 128
        wreg(OFS_CMP_LO, 8'h20);
        wreg(OFS_CMP_HI, 8'h00);
        for (int k = 0; k < 7; k++) begin
            wreg(OFS_CTL_A, 8'h11);
            if (k == 6) wreg(OFS_CMP_LO, 8'h40);
            if (k == 6) wreg(OFS_CMP_HI, 8'h00);
            wreg(OFS_CTL_B, cb[k]);
            wreg(OFS_CTL_A, 8'h19);
            run(8);
            run(1280);
            d = hi_n - e[k];
            chk(d >= -2 && d <= 2, "pwm high");
        end
    endtask
    task automatic print_verdict;
        $display("failures=%0d n_compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #800000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        t_regs();
        t_clocks();
        t_pause();
        t_cmp();
        t_pwm();
        print_verdict();
    end
endmodule
